// *** logic/pmd_pkg.sv ***
// Package for the peripheral disable register block.
// Assumes an AXI4-Lite master in the same clock domain.
package pmd_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] CTRL_TWO_ADDR = 4'h0;
  localparam logic [15:0] CTRL_TWO_RESET = 16'h0000;
  localparam logic [15:0] CTRL_TWO_MASK = 16'h0422;
  localparam int COMPARATOR_OFF_POS = 10;
  localparam int ENCODER_TWO_OFF_POS = 5;
  localparam int I2C_SECOND_OFF_POS = 1;

  // ************************************************************
  // Bus constants
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic comparator_off;
    logic encoder_two_off;
    logic i2c_second_off;
  } pmd_disable_t;

endpackage : pmd_pkg

// *** logic/pmd_regs.sv ***
// Peripheral disable control register two behind an AXI4-Lite slave.
// Assumes one clock, synchronous active-low reset, one write and one read at a time.
module pmd_regs (
  input wire logic i_clk, // 25 MHz clock
  input wire logic i_rst_n, // Synchronous reset, active low
  input wire logic [3:0] i_awaddr, // Write address
  input wire logic i_awvalid, // Write address valid
  output logic o_awready, // Write address ready
  input wire logic [31:0] i_wdata, // Write data
  input wire logic [3:0] i_wstrb, // Write byte strobes
  input wire logic i_wvalid, // Write data valid
  output logic o_wready, // Write data ready
  output logic [1:0] o_bresp, // Write response
  output logic o_bvalid, // Write response valid
  input wire logic i_bready, // Write response ready
  input wire logic [3:0] i_araddr, // Read address
  input wire logic i_arvalid, // Read address valid
  output logic o_arready, // Read address ready
  output logic [31:0] o_rdata, // Read data
  output logic [1:0] o_rresp, // Read response
  output logic o_rvalid, // Read data valid
  input wire logic i_rready, // Read data ready
  output pmd_pkg::pmd_disable_t o_disable // Per-module disable levels
);

  // ************************************************************
  // Write channel
  // ************************************************************
  logic aw_held, next_aw_held;
  logic [3:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic [15:0] ctrl_two, next_ctrl_two;
  logic [1:0] bresp, next_bresp;
  logic bvalid, next_bvalid;
  logic awready, next_awready;
  logic wready, next_wready;
  logic write_commit;
  logic write_mapped;

  assign write_commit = aw_held && w_held;
  assign write_mapped = aw_addr[3:2] == pmd_pkg::CTRL_TWO_ADDR[3:2];

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_ctrl_two = ctrl_two;
    next_bresp = bresp;
    next_bvalid = bvalid;
    if (i_awvalid && !aw_held && !bvalid) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && !w_held && !bvalid) begin
      next_w_held = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    if (aw_held && w_held) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      if (aw_addr[3:2] == pmd_pkg::CTRL_TWO_ADDR[3:2]) begin
        next_bresp = pmd_pkg::RESP_OKAY;
        if (w_strb[0]) begin
          next_ctrl_two[7:0] = w_data[7:0] & pmd_pkg::CTRL_TWO_MASK[7:0];
        end
        if (w_strb[1]) begin
          next_ctrl_two[15:8] = w_data[15:8] & pmd_pkg::CTRL_TWO_MASK[15:8];
        end
      end else begin
        next_bresp = pmd_pkg::RESP_SLVERR;
      end
    end else if (bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    // Ready flops follow the next hold flags and the next bvalid so the ports come from registers
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl_two <= pmd_pkg::CTRL_TWO_RESET;
      bresp <= pmd_pkg::RESP_OKAY;
      bvalid <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      ctrl_two <= next_ctrl_two;
      bresp <= next_bresp;
      bvalid <= next_bvalid;
      awready <= next_awready;
      wready <= next_wready;
    end
  end

  // ************************************************************
  // Disable outputs
  // ************************************************************
  pmd_pkg::pmd_disable_t dis, next_dis;

  // Disable levels track the register one clock behind
  always_comb begin
    next_dis.comparator_off = ctrl_two[pmd_pkg::COMPARATOR_OFF_POS];
    next_dis.encoder_two_off = ctrl_two[pmd_pkg::ENCODER_TWO_OFF_POS];
    next_dis.i2c_second_off = ctrl_two[pmd_pkg::I2C_SECOND_OFF_POS];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dis <= '0;
    end else begin
      dis <= next_dis;
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic rvalid, next_rvalid;
  logic arready, next_arready;

  always_comb begin
    next_rdata = rdata;
    next_rresp = rresp;
    next_rvalid = rvalid;
    next_arready = !rvalid && !(i_arvalid && arready);
    if (i_arvalid && arready) begin
      next_rvalid = 1'b1;
      if (i_araddr[3:2] == pmd_pkg::CTRL_TWO_ADDR[3:2]) begin
        next_rdata = {16'h0000, ctrl_two & pmd_pkg::CTRL_TWO_MASK};
        next_rresp = pmd_pkg::RESP_OKAY;
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = pmd_pkg::RESP_SLVERR;
      end
    end else if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata <= 32'h0000_0000;
      rresp <= pmd_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      arready <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rresp <= next_rresp;
      rvalid <= next_rvalid;
      arready <= next_arready;
    end
  end

  assign o_awready = awready;
  assign o_wready = wready;
  assign o_bresp = bresp;
  assign o_bvalid = bvalid;
  assign o_arready = arready;
  assign o_rdata = rdata;
  assign o_rresp = rresp;
  assign o_rvalid = rvalid;
  assign o_disable = dis;

  // ************************************************************
  // Checks: register and disable outputs
  // ************************************************************
  comparator_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 dis.comparator_off == $past(ctrl_two[pmd_pkg::COMPARATOR_OFF_POS]))
    else $error("comparator disable lags register");

  encoder_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 dis.encoder_two_off == $past(ctrl_two[pmd_pkg::ENCODER_TWO_OFF_POS]))
    else $error("encoder disable lags register");

  i2c_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 dis.i2c_second_off == $past(ctrl_two[pmd_pkg::I2C_SECOND_OFF_POS]))
    else $error("i2c disable lags register");

  comparator_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(ctrl_two[pmd_pkg::COMPARATOR_OFF_POS]) |=> dis.comparator_off)
    else $error("comparator disable not raised next clock");

  clear_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(ctrl_two[pmd_pkg::COMPARATOR_OFF_POS]) |=> !dis.comparator_off)
    else $error("disable not released next clock");

  encoder_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(ctrl_two[pmd_pkg::ENCODER_TWO_OFF_POS]) |=> !dis.encoder_two_off)
    else $error("encoder disable not released next clock");

  i2c_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(ctrl_two[pmd_pkg::I2C_SECOND_OFF_POS]) |=> !dis.i2c_second_off)
    else $error("i2c disable not released next clock");

  unused_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ctrl_two & ~pmd_pkg::CTRL_TWO_MASK) == 16'h0000)
    else $error("unimplemented bit set");

  read_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rvalid |-> (rdata & ~{16'h0000, pmd_pkg::CTRL_TWO_MASK}) == 32'h0000_0000)
    else $error("read shows unimplemented bit");

  write_done_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (write_commit && write_mapped && w_strb[1]) |=> ctrl_two[pmd_pkg::COMPARATOR_OFF_POS] == $past(w_data[10]))
    else $error("bit 10 write lost");

  encoder_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (write_commit && write_mapped && w_strb[0]) |=> ctrl_two[pmd_pkg::ENCODER_TWO_OFF_POS] == $past(w_data[5]))
    else $error("bit 5 write lost");

  i2c_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (write_commit && write_mapped && w_strb[0]) |=> ctrl_two[pmd_pkg::I2C_SECOND_OFF_POS] == $past(w_data[1]))
    else $error("bit 1 write lost");

  write_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (write_commit && write_mapped && w_strb[0]) |=>
    ##1 dis.i2c_second_off == $past(w_data[pmd_pkg::I2C_SECOND_OFF_POS], 2))
    else $error("bit 1 write not on output");

  ctrl_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !write_commit |=> $stable(ctrl_two))
    else $error("register changed without a write");

  unmapped_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (write_commit && !write_mapped) |=> $stable(ctrl_two))
    else $error("unmapped write changed register");

  high_lane_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (write_commit && !w_strb[1]) |=> $stable(ctrl_two[15:8]))
    else $error("high byte written without strobe");

  low_lane_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (write_commit && !w_strb[0]) |=> $stable(ctrl_two[7:0]))
    else $error("low byte written without strobe");

  read_match_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_arvalid && arready && i_araddr[3:2] == pmd_pkg::CTRL_TWO_ADDR[3:2]) |=>
    rdata == {16'h0000, $past(ctrl_two)} && rresp == pmd_pkg::RESP_OKAY)
    else $error("read data differs from register");

  // ************************************************************
  // Checks: write bus
  // ************************************************************
  aw_taken_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (awready && i_awvalid) |=> !awready)
    else $error("write address ready stayed high");

  w_taken_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wready && i_wvalid) |=> !wready)
    else $error("write data ready stayed high");

  write_answer_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    write_commit |=> bvalid)
    else $error("write response missing");

  write_okay_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (write_commit && write_mapped) |=> bresp == pmd_pkg::RESP_OKAY)
    else $error("mapped write not answered okay");

  write_slverr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (write_commit && !write_mapped) |=> bresp == pmd_pkg::RESP_SLVERR)
    else $error("unmapped write not answered with error");

  bvalid_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bvalid && !i_bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  bvalid_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bvalid && i_bready) |=> !bvalid && awready && wready)
    else $error("write response not retired");

  // ************************************************************
  // Checks: read bus
  // ************************************************************
  read_answer_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_arvalid && arready) |=> rvalid && !arready)
    else $error("read response missing");

  read_slverr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_arvalid && arready && i_araddr[3:2] != pmd_pkg::CTRL_TWO_ADDR[3:2]) |=>
    rresp == pmd_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not answered with error");

  rvalid_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rvalid && !i_rready) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped early");

  rvalid_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rvalid && i_rready) |=> !rvalid && arready)
    else $error("read response not retired");

  ar_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rvalid |-> !arready)
    else $error("read address ready while answer pending");

endmodule : pmd_regs

// *** sim/peripheral_module_disable_test.sv ***
// Self-checking bench for the peripheral disable register block.
// Assumes pmd_regs with an AXI4-Lite slave, one clock and synchronous reset.
module peripheral_module_disable_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hF;
  logic [31:0] i_wdata = 32'h0000_0000, rd;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, rs;
  logic [31:0] o_rdata;
  pmd_pkg::pmd_disable_t o_disable;
  int bad_count = 0, comparisons = 0;
  logic [15:0] wv [4] = '{16'h0400, 16'h0020, 16'h0002, 16'h0422};
  logic [2:0] dv [4] = '{3'h4, 3'h2, 3'h1, 3'h7};
  pmd_regs i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_disable(o_disable));
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : check
  // Reports an answer channel that stayed silent; a missing answer ends the run
  task automatic timed_out;
    $display("CHECK FAILED bus answer expected 1 seen 0");
    bad_count++;
    final_report();
  endtask : timed_out
  task automatic bus_write(input logic [3:0] addr, input logic [31:0] data, output logic [1:0] resp);
    bit done;
    done = 0;
    @(posedge i_clk);
    i_awaddr <= addr;
    i_wdata <= data;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid === 1'b1) begin
        resp = o_bresp;
        done = 1;
      end
    end
    i_bready <= 1'b0;
    if (!done) timed_out();
  endtask : bus_write
  task automatic bus_read(input logic [3:0] addr, output logic [31:0] data, output logic [1:0] resp);
    bit done;
    done = 0;
    @(posedge i_clk);
    i_araddr <= addr;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid === 1'b1) begin
        data = o_rdata;
        resp = o_rresp;
        done = 1;
      end
    end
    i_rready <= 1'b0;
    if (!done) timed_out();
  endtask : bus_read
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus_read(4'h0, rd, rs);
    check("reset value", 32'h0000_0000, rd);
    check("read response", {30'h0, pmd_pkg::RESP_OKAY}, {30'h0, rs});
    check("disable after reset", 32'h0000_0000, {29'h0, o_disable});
    $display("Test reset values done");
    for (int i = 0; i < 4; i++) begin
      bus_write(4'h0, {16'hFFFF, wv[i] | 16'hFBDD}, rs);
      check("write response", {30'h0, pmd_pkg::RESP_OKAY}, {30'h0, rs});
      bus_read(4'h0, rd, rs);
      check("register readback", {16'h0000, wv[i]}, rd);
      check("disable outputs", {29'h0, dv[i]}, {29'h0, o_disable});
    end
    bus_write(4'h0, 32'h0000_0000, rs);
    bus_read(4'h0, rd, rs);
    check("disable cleared", 32'h0000_0000, {29'h0, o_disable});
    $display("Test bit set and clear done");
    i_wstrb <= 4'h2;
    bus_write(4'h0, 32'hFFFF_FFFF, rs);
    bus_read(4'h0, rd, rs);
    check("high lane write", 32'h0000_0400, rd);
    i_wstrb <= 4'h1;
    bus_write(4'h0, 32'hFFFF_FFFF, rs);
    bus_read(4'h0, rd, rs);
    check("low lane write", 32'h0000_0422, rd);
    i_wstrb <= 4'h2;
    bus_write(4'h0, 32'h0000_0000, rs);
    bus_read(4'h0, rd, rs);
    check("high lane clear", 32'h0000_0022, rd);
    check("disable after lane clear", 32'h0000_0003, {29'h0, o_disable});
    i_wstrb <= 4'hF;
    $display("Test byte strobes done");
    bus_write(4'h4, 32'hFFFF_FFFF, rs);
    check("unmapped write response", {30'h0, pmd_pkg::RESP_SLVERR}, {30'h0, rs});
    bus_read(4'h4, rd, rs);
    check("unmapped read response", {30'h0, pmd_pkg::RESP_SLVERR}, {30'h0, rs});
    check("unmapped read data", 32'h0000_0000, rd);
    bus_read(4'h0, rd, rs);
    check("register kept", 32'h0000_0022, rd);
    $display("Test unmapped address done");
    bus_write(4'h0, 32'h0000_0422, rs);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus_read(4'h0, rd, rs);
    check("value after second reset", 32'h0000_0000, rd);
    check("disable after second reset", 32'h0000_0000, {29'h0, o_disable});
    $display("Test second reset done");
    final_report();
  end
endmodule : peripheral_module_disable_test
